/* hdl/fsc_pkg.sv */
package fsc_pkg;

  // Bus and register map
  localparam int         FSC_AXI_AW    = 8;
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_LOG_OP    = 8'h08;
  localparam logic [7:0] REG_LOG_ADDR  = 8'h0c;
  localparam logic [7:0] REG_RST_CNT   = 8'h10;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;

  // Status register bit positions
  localparam int ST_WEL_BIT  = 8;
  localparam int ST_VWE_BIT  = 9;
  localparam int ST_VACT_BIT = 10;
  localparam int ST_A4_BIT   = 11;
  localparam int ST_REN_BIT  = 12;

  // Bus width modes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DUAL   = 2'h1;

  // Phase lengths in bits
  localparam logic [5:0] LEN_OP    = 6'h08;
  localparam logic [5:0] LEN_A3    = 6'h18;
  localparam logic [5:0] LEN_A4    = 6'h20;
  localparam logic [5:0] LEN_DUMMY = 6'h08;
  localparam logic [5:0] LEN_BYTE  = 6'h08;

  // Opcodes
  localparam logic [7:0] OP_WREN   = 8'h06;
  localparam logic [7:0] OP_VWE    = 8'h50;
  localparam logic [7:0] OP_WRSR   = 8'h01;
  localparam logic [7:0] OP_RDSR   = 8'h05;
  localparam logic [7:0] OP_RSTEN  = 8'h66;
  localparam logic [7:0] OP_RST    = 8'h99;
  localparam logic [7:0] OP_EN4    = 8'hb7;
  localparam logic [7:0] OP_EX4    = 8'he9;
  localparam logic [7:0] OP_RD4    = 8'h13;
  localparam logic [7:0] OP_FRD4   = 8'h0c;
  localparam logic [7:0] OP_DORD4  = 8'h3c;
  localparam logic [7:0] OP_DIORD4 = 8'hbc;
  localparam logic [7:0] OP_QORD4  = 8'h6c;
  localparam logic [7:0] OP_QIORD4 = 8'hec;
  localparam logic [7:0] OP_PP4    = 8'h12;
  localparam logic [7:0] OP_QPP4   = 8'h34;
  localparam logic [7:0] OP_ER1    = 8'h21;
  localparam logic [7:0] OP_ER2    = 8'h5c;
  localparam logic [7:0] OP_ER3    = 8'hdc;
  localparam logic [7:0] OP_SFDP   = 8'h5a;

  // Parameter table contents
  localparam logic [8:0] PT_A_6C = 9'h06c;
  localparam logic [8:0] PT_A_6D = 9'h06d;
  localparam logic [8:0] PT_A_6E = 9'h06e;
  localparam logic [8:0] PT_A_6F = 9'h06f;
  localparam logic [8:0] PT_A_C0 = 9'h0c0;
  localparam logic [8:0] PT_A_C1 = 9'h0c1;
  localparam logic [8:0] PT_A_C2 = 9'h0c2;
  localparam logic [8:0] PT_A_C4 = 9'h0c4;
  localparam logic [8:0] PT_A_C5 = 9'h0c5;
  localparam logic [8:0] PT_A_C6 = 9'h0c6;
  localparam logic [7:0] PT_D_6C = 8'he8;
  localparam logic [7:0] PT_D_6D = 8'h50;
  localparam logic [7:0] PT_D_6E = 8'hc1;
  localparam logic [7:0] PT_D_6F = 8'ha5;
  localparam logic [7:0] PT_D_C0 = 8'hff;
  localparam logic [7:0] PT_D_C1 = 8'h0e;
  localparam logic [7:0] PT_D_C2 = 8'hf0;
  localparam logic [7:0] PT_D_FILL = 8'hff;

  typedef enum logic [2:0] {
    FR_OPCODE, FR_ADDR, FR_DUMMY, FR_DIN, FR_DOUT, FR_IGNORE
  } fsc_frame_type;

  typedef enum logic [3:0] {
    CL_NONE, CL_WREN, CL_VWE, CL_WRSR, CL_RDSR, CL_RSTEN, CL_RST,
    CL_EN4, CL_EX4, CL_READ4, CL_PROG4, CL_ERASE4, CL_SFDP
  } fsc_cls_type;

  typedef struct packed {
    fsc_frame_type st;
    fsc_cls_type   cls;
    logic          sclk_p;
    logic [5:0]    cnt;
    logic [5:0]    len;
    logic [2:0]    lanes;
    logic [31:0]   sh;
    logic [7:0]    op;
    logic [7:0]    obyte;
    logic [2:0]    ocnt;
    logic [8:0]    oaddr;
    logic [7:0]    nv_sr;
    logic [7:0]    vol_sr;
    logic          vol_act;
    logic          wel;
    logic          vwe;
    logic          addr4;
    logic          rst_en;
    logic [1:0]    mode;
    logic [7:0]    log_op;
    logic [31:0]   log_addr;
    logic [15:0]   log_cnt;
    logic [15:0]   rst_cnt;
    logic          aw_got;
    logic          w_got;
    logic [7:0]    awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic          awready;
    logic          wready;
    logic          bvalid;
    logic [1:0]    bresp;
    logic          arready;
    logic          rvalid;
    logic [31:0]   rdata;
    logic [1:0]    rresp;
    logic [3:0]    dq_o;
    logic [3:0]    dq_oe;
  } fsc_state_type;

endpackage : fsc_pkg

/* hdl/fsc_sync.sv */
`timescale 1ns/1ps
module fsc_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } fsc_sync_st_type;

  fsc_sync_st_type s_q;
  fsc_sync_st_type s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = d;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    // Change is taken only where stages two and three agree
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.f[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= {INIT, INIT, INIT, INIT};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.f;

endmodule : fsc_sync

/* hdl/fsc_top.sv */
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Status loads stored copy; stored write needs 06h
// - 50h enables volatile status write, overriding copy
// - Soft reset only on 99h right after 66h
// - Reset pair accepted on current 1/2/4 lanes
// - B7h enters, E9h exits 4-byte mode, no 06h
// - Decode 13h and 0Ch with four-byte address
// - Decode dual reads 3Ch and BCh
// - Decode quad reads 6Ch and ECh
// - Accept 4-byte programs 12h and 34h
// - No support for 3Eh quad program
// - Erase types 1-3 supported, type 4 not
// - No support for DTR reads 0Eh, BEh, EEh
// - No sector lock commands E0h, E1h, others
// - Table bytes 6Ch..6Fh read E8,50,C1,A5
// - Table bytes C0h..C2h read FF,0E,F0
// - Erase opcodes 21h, 5Ch, DCh; none type 4
module fsc_top
  import fsc_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [FSC_AXI_AW-1:0] awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [FSC_AXI_AW-1:0] araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic                  spi_sclk,
  input  wire logic                  spi_cs_n,
  input  wire logic [3:0]            spi_dq_i,
  output logic [3:0]                 spi_dq_o,
  output logic [3:0]                 spi_dq_oe
);

  fsc_state_type s_q;
  fsc_state_type s_d;
  logic [5:0]    pin_f;
  logic          rise;
  logic          fall;
  logic          cs_hi;
  logic [5:0]    ncnt;
  logic [31:0]   sh_n;
  logic          op_done;
  fsc_cls_type   cls_now;

  function automatic fsc_cls_type decode(input logic [7:0] op);
    case (op)
      OP_WREN:  decode = CL_WREN;
      OP_VWE:   decode = CL_VWE;
      OP_WRSR:  decode = CL_WRSR;
      OP_RDSR:  decode = CL_RDSR;
      OP_RSTEN: decode = CL_RSTEN;
      OP_RST:   decode = CL_RST;
      OP_EN4:   decode = CL_EN4;
      OP_EX4:   decode = CL_EX4;
      OP_RD4, OP_FRD4, OP_DORD4, OP_DIORD4,
      OP_QORD4, OP_QIORD4: decode = CL_READ4;
      OP_PP4, OP_QPP4:     decode = CL_PROG4;
      OP_ER1, OP_ER2, OP_ER3: decode = CL_ERASE4;
      OP_SFDP:  decode = CL_SFDP;
      default:  decode = CL_NONE;
    endcase
  endfunction : decode

  function automatic logic [2:0] lanes_of(input logic [1:0] mode);
    case (mode)
      MODE_SINGLE: lanes_of = 3'h1;
      MODE_DUAL:   lanes_of = 3'h2;
      default:     lanes_of = 3'h4;
    endcase
  endfunction : lanes_of

  function automatic logic [2:0] addr_lanes(input logic [7:0] op,
                                            input logic [1:0] mode);
    if (mode != MODE_SINGLE) begin
      addr_lanes = lanes_of(mode);
    end else if (op == OP_DIORD4) begin
      addr_lanes = 3'h2;
    end else if (op == OP_QIORD4) begin
      addr_lanes = 3'h4;
    end else begin
      addr_lanes = 3'h1;
    end
  endfunction : addr_lanes

  function automatic logic [31:0] shift_in(input logic [31:0] sh,
                                           input logic [3:0]  dq,
                                           input logic [2:0]  lanes);
    case (lanes)
      3'h1:    shift_in = {sh[30:0], dq[0]};
      3'h2:    shift_in = {sh[29:0], dq[1:0]};
      default: shift_in = {sh[27:0], dq};
    endcase
  endfunction : shift_in

  function automatic logic [7:0] table_byte(input logic [8:0] a);
    case (a)
      PT_A_6C: table_byte = PT_D_6C;
      PT_A_6D: table_byte = PT_D_6D;
      PT_A_6E: table_byte = PT_D_6E;
      PT_A_6F: table_byte = PT_D_6F;
      PT_A_C0: table_byte = PT_D_C0;
      PT_A_C1: table_byte = PT_D_C1;
      PT_A_C2: table_byte = PT_D_C2;
      PT_A_C4: table_byte = OP_ER1;
      PT_A_C5: table_byte = OP_ER2;
      PT_A_C6: table_byte = OP_ER3;
      default: table_byte = PT_D_FILL;
    endcase
  endfunction : table_byte

  fsc_sync #(
    .W    (6),
    .INIT (6'h10)
  ) fsc_sync_i (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       ({spi_sclk, spi_cs_n, spi_dq_i}),
    .q       (pin_f)
  );

  assign cs_hi   = pin_f[4];
  assign rise    = pin_f[5] && !s_q.sclk_p && !cs_hi;
  assign fall    = !pin_f[5] && s_q.sclk_p && !cs_hi;
  assign ncnt    = s_q.cnt + {3'h0, s_q.lanes};
  assign sh_n    = shift_in(s_q.sh, pin_f[3:0], s_q.lanes);
  assign op_done = rise && s_q.st == FR_OPCODE && ncnt == s_q.len;
  assign cls_now = decode(sh_n[7:0]);

  always_comb begin
    s_d = s_q;
    // Register bus, write side
    if (awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.awaddr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = wdata;
      s_d.wstrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = RESP_SLVERR;
      if (s_q.awaddr == REG_CTRL) begin
        s_d.bresp = RESP_OKAY;
        if (s_q.wstrb[0]) begin
          s_d.mode = s_q.wdata[1:0];
        end
      end
    end
    s_d.awready = !s_d.aw_got && !s_d.bvalid;
    s_d.wready  = !s_d.w_got && !s_d.bvalid;
    // Register bus, read side
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && s_q.arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = RESP_OKAY;
      s_d.rdata  = '0;
      case (araddr)
        REG_CTRL: s_d.rdata[1:0] = s_q.mode;
        REG_STATUS: begin
          s_d.rdata[7:0]         = s_q.vol_sr;
          s_d.rdata[ST_WEL_BIT]  = s_q.wel;
          s_d.rdata[ST_VWE_BIT]  = s_q.vwe;
          s_d.rdata[ST_VACT_BIT] = s_q.vol_act;
          s_d.rdata[ST_A4_BIT]   = s_q.addr4;
          s_d.rdata[ST_REN_BIT]  = s_q.rst_en;
        end
        REG_LOG_OP:   s_d.rdata = {s_q.log_cnt, 8'h00, s_q.log_op};
        REG_LOG_ADDR: s_d.rdata = s_q.log_addr;
        REG_RST_CNT:  s_d.rdata = {16'h0000, s_q.rst_cnt};
        default:      s_d.rresp = RESP_SLVERR;
      endcase
    end
    s_d.arready = !s_d.rvalid;
    // Serial side
    s_d.sclk_p = pin_f[5];
    if (cs_hi) begin
      s_d.st    = FR_OPCODE;
      s_d.cnt   = '0;
      s_d.len   = LEN_OP;
      s_d.lanes = lanes_of(s_q.mode);
      s_d.ocnt  = '0;
      s_d.dq_oe = '0;
    end else if (rise && s_q.st != FR_DOUT && s_q.st != FR_IGNORE) begin
      s_d.sh  = sh_n;
      s_d.cnt = ncnt;
      if (ncnt == s_q.len) begin
        s_d.cnt = '0;
        s_d.st  = FR_IGNORE;
        case (s_q.st)
          FR_OPCODE: begin
            s_d.op     = sh_n[7:0];
            s_d.cls    = cls_now;
            s_d.rst_en = 1'b0;
            case (cls_now)
              CL_WREN:  s_d.wel = 1'b1;
              CL_VWE:   s_d.vwe = 1'b1;
              CL_RSTEN: s_d.rst_en = 1'b1;
              CL_RST: begin
                if (s_q.rst_en) begin
                  s_d.vol_sr  = s_q.nv_sr;
                  s_d.vol_act = 1'b0;
                  s_d.wel     = 1'b0;
                  s_d.vwe     = 1'b0;
                  s_d.addr4   = 1'b0;
                  s_d.rst_cnt = s_q.rst_cnt + 16'h0001;
                end
              end
              CL_EN4:   s_d.addr4 = 1'b1;
              CL_EX4:   s_d.addr4 = 1'b0;
              CL_WRSR: begin
                if (s_q.wel || s_q.vwe) begin
                  s_d.st  = FR_DIN;
                  s_d.len = LEN_BYTE;
                end
              end
              CL_RDSR: begin
                s_d.st    = FR_DOUT;
                s_d.obyte = s_q.vol_sr;
              end
              CL_READ4, CL_PROG4, CL_ERASE4: begin
                if (cls_now == CL_READ4 || s_q.wel) begin
                  s_d.st    = FR_ADDR;
                  s_d.len   = LEN_A4;
                  s_d.lanes = addr_lanes(sh_n[7:0], s_q.mode);
                end
              end
              CL_SFDP: begin
                s_d.st  = FR_ADDR;
                s_d.len = LEN_A3;
              end
              default: s_d.st = FR_IGNORE;
            endcase
          end
          FR_ADDR: begin
            s_d.log_addr = sh_n;
            if (s_q.cls == CL_SFDP) begin
              s_d.oaddr = sh_n[8:0];
              s_d.st    = FR_DUMMY;
              s_d.len   = LEN_DUMMY;
              s_d.lanes = 3'h1;
            end else begin
              s_d.log_op  = s_q.op;
              s_d.log_cnt = s_q.log_cnt + 16'h0001;
              if (s_q.cls != CL_READ4) begin
                s_d.wel = 1'b0;
              end
            end
          end
          FR_DUMMY: begin
            s_d.st    = FR_DOUT;
            s_d.obyte = table_byte(s_q.oaddr);
            s_d.oaddr = s_q.oaddr + 9'h001;
          end
          FR_DIN: begin
            if (s_q.vwe) begin
              s_d.vol_sr  = sh_n[7:0];
              s_d.vol_act = 1'b1;
              s_d.vwe     = 1'b0;
            end else begin
              s_d.nv_sr  = sh_n[7:0];
              s_d.vol_sr = sh_n[7:0];
              s_d.wel    = 1'b0;
            end
          end
          default: s_d.st = FR_IGNORE;
        endcase
      end
    end else if (fall && s_q.st == FR_DOUT) begin
      s_d.dq_o[1]  = s_q.obyte[7];
      s_d.dq_oe[1] = 1'b1;
      s_d.obyte    = {s_q.obyte[6:0], 1'b0};
      s_d.ocnt     = s_q.ocnt + 3'h1;
      if (s_q.ocnt == 3'h7) begin
        if (s_q.cls == CL_SFDP) begin
          s_d.obyte = table_byte(s_q.oaddr);
          s_d.oaddr = s_q.oaddr + 9'h001;
        end else begin
          s_d.obyte = s_q.vol_sr;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q      <= '0;
      s_q.mode <= CTRL_MODE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign awready   = s_q.awready;
  assign wready    = s_q.wready;
  assign bvalid    = s_q.bvalid;
  assign bresp     = s_q.bresp;
  assign arready   = s_q.arready;
  assign rvalid    = s_q.rvalid;
  assign rdata     = s_q.rdata;
  assign rresp     = s_q.rresp;
  assign spi_dq_o  = s_q.dq_o;
  assign spi_dq_oe = s_q.dq_oe;

  property p_nv_needs_wel;
    @(posedge aclk) disable iff (!aresetn)
    $changed(s_q.nv_sr) |-> $past(s_q.wel);
  endproperty
  a_nv_needs_wel: assert property (p_nv_needs_wel)
    else $error("stored status changed without write enable");

  property p_vol_act;
    @(posedge aclk) disable iff (!aresetn)
    $rose(s_q.vol_act) |-> $past(s_q.vwe) && !s_q.vwe;
  endproperty
  a_vol_act: assert property (p_vol_act)
    else $error("volatile status activated without 50h");

  property p_reset_pair;
    @(posedge aclk) disable iff (!aresetn)
    s_q.rst_cnt != $past(s_q.rst_cnt) |-> $past(s_q.rst_en)
      && !s_q.addr4 && !s_q.wel;
  endproperty
  a_reset_pair: assert property (p_reset_pair)
    else $error("soft reset without preceding 66h");

  property p_lanes_mode;
    @(posedge aclk) disable iff (!aresetn)
    cs_hi ##1 (cs_hi && $past(aresetn)) |->
      s_q.lanes == lanes_of($past(s_q.mode));
  endproperty
  a_lanes_mode: assert property (p_lanes_mode)
    else $error("opcode lanes do not follow mode");

  property p_enter4;
    @(posedge aclk) disable iff (!aresetn)
    op_done && cls_now == CL_EN4 |=> s_q.addr4 ##1 s_q.addr4 || cs_hi
      || $past(op_done);
  endproperty
  a_enter4: assert property (p_enter4)
    else $error("B7h did not set 4-byte mode");

  property p_read4_addr;
    @(posedge aclk) disable iff (!aresetn)
    op_done && cls_now == CL_READ4 |=> s_q.st == FR_ADDR
      && s_q.len == LEN_A4;
  endproperty
  a_read4_addr: assert property (p_read4_addr)
    else $error("4-byte read did not take 32 address bits");

  property p_prog_wel;
    @(posedge aclk) disable iff (!aresetn)
    op_done && cls_now == CL_PROG4 && !s_q.wel |=> s_q.st == FR_IGNORE;
  endproperty
  a_prog_wel: assert property (p_prog_wel)
    else $error("program accepted without write enable");

  property p_unsup;
    @(posedge aclk) disable iff (!aresetn)
    op_done && cls_now == CL_NONE |=> s_q.st == FR_IGNORE
      && $stable(s_q.nv_sr) && $stable(s_q.wel) && $stable(s_q.addr4);
  endproperty
  a_unsup: assert property (p_unsup)
    else $error("unsupported opcode changed state");

  property p_dout_bit;
    @(posedge aclk) disable iff (!aresetn)
    fall && s_q.st == FR_DOUT |=> s_q.dq_oe[1]
      && s_q.dq_o[1] == $past(s_q.obyte[7]);
  endproperty
  a_dout_bit: assert property (p_dout_bit)
    else $error("output bit not driven from shift byte");

  c_soft_reset: cover property (@(posedge aclk) disable iff (!aresetn)
    s_q.rst_cnt != $past(s_q.rst_cnt));
  c_table_read: cover property (@(posedge aclk) disable iff (!aresetn)
    s_q.st == FR_DOUT && s_q.cls == CL_SFDP && s_q.ocnt == 3'h7);
  c_enter4: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.addr4));
  c_vol_write: cover property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_q.vol_act));

endmodule : fsc_top

/* tb/fsc_host.sv */
`timescale 1ns/1ps
module fsc_host (
  input  wire logic       aclk,
  output logic            sclk,
  output logic            cs_n,
  output logic [3:0]      dq,
  input  wire logic [3:0] dq_o,
  input  wire logic [3:0] dq_oe
);
  localparam int H = 10;

  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    dq   = 4'h5;
  end

  task automatic clk_bit(input logic [3:0] v, output logic s);
    dq <= v;
    repeat (H) @(posedge aclk);
    s = dq_oe[1] ? dq_o[1] : 1'b1;
    sclk <= 1'b1;
    repeat (H) @(posedge aclk);
    sclk <= 1'b0;
  endtask : clk_bit

  // MSB first, w lanes per clock, highest lane most significant
  task automatic send(input logic [31:0] v, input int nb, input int w);
    logic s;
    for (int i = nb - w; i >= 0; i -= w) begin
      clk_bit(4'((v >> i) & ((32'h1 << w) - 1)), s);
    end
  endtask : send

  // One instruction per frame; opcode on ow lanes, address on aw lanes
  task automatic xfer(input logic [7:0] op, input int nab,
                      input logic [31:0] a, input int nd,
                      input bit nr, output logic [7:0] rd,
                      input int ow = 1, input int aw = 1);
    logic s;
    rd = 8'h00;
    cs_n <= 1'b0;
    repeat (H) @(posedge aclk);
    send({24'h0, op}, 8, ow);
    send(a, nab, aw);
    repeat (nd) clk_bit(4'h0, s);
    if (nr) begin
      for (int i = 7; i >= 0; i--) begin
        clk_bit(4'h0, s);
        rd[i] = s;
      end
    end
    repeat (H) @(posedge aclk);
    cs_n <= 1'b1;
    dq   <= ~dq;
    repeat (2 * H) @(posedge aclk);
  endtask : xfer
endmodule : fsc_host

/* tb/tb_fsc_top.sv */
`timescale 1ns/1ps
module tb_fsc_top;
  import fsc_pkg::*;
  logic                  aclk, aresetn;
  logic [FSC_AXI_AW-1:0] awaddr, araddr;
  logic                  awvalid, awready, wvalid, wready, bvalid, bready;
  logic                  arvalid, arready, rvalid, rready;
  logic [31:0]           wdata, rdata, d;
  logic [3:0]            wstrb, sdq_i, sdq_o, sdq_oe;
  logic [1:0]            bresp, rresp, r;
  logic                  sclk, cs_n;
  logic [7:0]            b;
  int                    fails, checks_done;
  logic [7:0] ops [9] = '{OP_RD4, OP_FRD4, OP_DORD4, OP_QORD4, OP_PP4,
                          OP_QPP4, OP_ER1, OP_ER2, OP_ER3};
  logic [7:0] bad [6] = '{8'h3e, 8'h0e, 8'hbe, 8'hee, 8'he0, 8'he1};
  logic [7:0] pa [10] = '{8'h6c, 8'h6d, 8'h6e, 8'h6f, 8'hc0, 8'hc1, 8'hc2,
                          8'hc4, 8'hc5, 8'hc6};
  logic [7:0] pd [10] = '{8'he8, 8'h50, 8'hc1, 8'ha5, 8'hff, 8'h0e, 8'hf0,
                          8'h21, 8'h5c, 8'hdc};

  fsc_top fsc_top_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_dq_i(sdq_i),
    .spi_dq_o(sdq_o), .spi_dq_oe(sdq_oe));
  fsc_host fsc_host_i (.aclk(aclk), .sclk(sclk), .cs_n(cs_n), .dq(sdq_i),
    .dq_o(sdq_o), .dq_oe(sdq_oe));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
                        output logic [1:0] rs);
    int n;
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 200);
    if (n == 200) fails++;
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v,
                        output logic [1:0] rs);
    int n;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 200);
    if (n == 200) fails++;
    v = rdata; rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic sp(input logic [7:0] op, input int nab = 0,
                    input logic [31:0] a = 0, input int ow = 1,
                    input int aw = 1);
    fsc_host_i.xfer(op, nab, a, 0, 1'b0, b, ow, aw);
  endtask : sp

  task automatic end_sim;
    if (fails == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : end_sim

  initial begin
    repeat (90000) @(posedge aclk);
    fails++;
    end_sim();
  end

  initial begin
    aresetn = 1'b0; awaddr = '0; awvalid = 1'b0; wdata = '0;
    wstrb = 4'hf; wvalid = 1'b0; bready = 1'b0; araddr = '0;
    arvalid = 1'b0; rready = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(REG_STATUS, d, r); chk("status", 32'h0, d);
    axi_rd(8'h14, d, r); chk("bad rdata", 32'h0, d);
    chk("bad rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(8'h14, 32'hffffffff, r);
    chk("bad bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    axi_wr(REG_CTRL, {30'h0, MODE_DUAL}, r);
    chk("ctrl bresp", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_rd(REG_CTRL, d, r); chk("ctrl", {30'h0, MODE_DUAL}, {30'h0, d[1:0]});
    chk("ctrl rresp", {30'h0, RESP_OKAY}, {30'h0, r});
    axi_wr(REG_CTRL, {30'h0, MODE_SINGLE}, r);
    sp(OP_WRSR, 8, 32'ha5);
    axi_rd(REG_STATUS, d, r); chk("sr no wel", 32'h0, d);
    sp(OP_WREN);
    axi_rd(REG_STATUS, d, r); chk("sr wel", 32'h100, d);
    sp(OP_WRSR, 8, 32'h3c);
    axi_rd(REG_STATUS, d, r); chk("sr nv", 32'h3c, {24'h0, d[7:0]});
    sp(OP_VWE); sp(OP_WRSR, 8, 32'h5a);
    axi_rd(REG_STATUS, d, r);
    chk("sr vol", 32'h15a, {23'h0, d[10], d[7:0]});
    sp(OP_EN4);
    axi_rd(REG_STATUS, d, r); chk("a4 on", 32'h1, {31'h0, d[11]});
    sp(OP_EX4);
    axi_rd(REG_STATUS, d, r); chk("a4 off", 32'h0, {31'h0, d[11]});
    sp(OP_RST);
    axi_rd(REG_RST_CNT, d, r); chk("rst lone", 32'h0, d);
    sp(OP_RSTEN);
    axi_rd(REG_STATUS, d, r); chk("rst en", 32'h1, {31'h0, d[12]});
    fsc_host_i.xfer(OP_RDSR, 0, 0, 0, 1'b1, b);
    chk("rdsr", 32'h5a, {24'h0, b});
    sp(OP_RST);
    axi_rd(REG_RST_CNT, d, r); chk("rst gap", 32'h0, d);
    sp(OP_RSTEN); sp(OP_RST);
    axi_rd(REG_RST_CNT, d, r); chk("rst pair", 32'h1, d);
    axi_rd(REG_STATUS, d, r);
    chk("sr reload", 32'h03c, {23'h0, d[10], d[7:0]});
    axi_wr(REG_CTRL, {30'h0, MODE_DUAL}, r);
    sp(OP_RSTEN, 0, 0, 2); sp(OP_RST, 0, 0, 2);
    axi_rd(REG_RST_CNT, d, r); chk("rst dual", 32'h2, d);
    axi_wr(REG_CTRL, 32'h2, r);
    sp(OP_RSTEN, 0, 0, 4); sp(OP_RST, 0, 0, 4);
    axi_rd(REG_RST_CNT, d, r); chk("rst quad", 32'h3, d);
    axi_wr(REG_CTRL, {30'h0, MODE_SINGLE}, r);
    foreach (ops[i]) begin
      sp(OP_WREN); sp(ops[i], 32, 32'h80000000 | i);
      axi_rd(REG_LOG_OP, d, r);
      chk("log op", {16'(i + 1), 8'h0, ops[i]}, {d[31:16], 8'h0, d[7:0]});
      axi_rd(REG_LOG_ADDR, d, r); chk("log addr", 32'h80000000 | i, d);
    end
    sp(OP_PP4, 32, 32'h77);
    axi_rd(REG_LOG_OP, d, r);
    chk("pp no wel", {16'h9, 8'h0, OP_ER3},
        {d[31:16], 8'h0, d[7:0]});
    foreach (bad[i]) begin
      sp(OP_WREN); sp(bad[i], 32, 32'h1234);
      axi_rd(REG_LOG_OP, d, r);
      chk("ignored", {16'h9, 8'h0, OP_ER3}, {d[31:16], 8'h0, d[7:0]});
    end
    sp(OP_DIORD4, 32, 32'h5a5a0001, 1, 2);
    axi_rd(REG_LOG_ADDR, d, r); chk("dual addr", 32'h5a5a0001, d);
    sp(OP_QIORD4, 32, 32'hc3c30002, 1, 4);
    axi_rd(REG_LOG_OP, d, r);
    chk("quad io", {16'hb, 8'h0, OP_QIORD4},
        {d[31:16], 8'h0, d[7:0]});
    axi_rd(REG_LOG_ADDR, d, r); chk("quad addr", 32'hc3c30002, d);
    foreach (pa[i]) begin
      fsc_host_i.xfer(OP_SFDP, 24, {24'h0, pa[i]}, 8, 1'b1, b);
      chk("table", {24'h0, pd[i]}, {24'h0, b});
    end
    end_sim();
  end
endmodule : tb_fsc_top
